// [src/rafc_pkg.sv]
package rafc_pkg;
  localparam int VW = 10;
  localparam int FW = 16;
  localparam int GW = 8;
  localparam int AW = 8;
  localparam int ACCW = 24;
  localparam int ACC_FRAC = 8;
  localparam int INC_SHIFT = 12;

  // APB register byte addresses
  localparam logic [AW-1:0] ADDR_MODE = 8'h00;
  localparam logic [AW-1:0] ADDR_LEVEL = 8'h04;
  localparam logic [AW-1:0] ADDR_LIMIT = 8'h08;
  localparam logic [AW-1:0] ADDR_VGAIN = 8'h0c;
  localparam logic [AW-1:0] ADDR_FGAIN = 8'h10;
  localparam logic [AW-1:0] ADDR_MAXF = 8'h14;
  localparam logic [AW-1:0] ADDR_VIS = 8'h18;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h1c;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [AW-1:0] ADDR_IRQ_CLR = 8'h24;
  localparam logic [AW-1:0] ADDR_IRQ_EN = 8'h28;

  // Mode codes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ALWAYS = 2'h1;
  localparam logic [1:0] MODE_CONST = 2'h2;

  // Reset values and ranges; volts, 0.01 Hz, percent
  localparam logic [1:0] MODE_RST = MODE_OFF;
  localparam logic [VW-1:0] LEVEL_RST_200V = 10'h190;
  localparam logic [VW-1:0] LEVEL_RST_400V = 10'h30c;
  localparam logic [VW-1:0] LEVEL_MIN = 10'h12c;
  localparam logic [VW-1:0] LEVEL_MAX = 10'h320;
  localparam logic [FW-1:0] LIMIT_RST = 16'h0258;
  localparam logic [FW-1:0] LIMIT_MAX = 16'h03e8;
  localparam logic [FW-1:0] LIMIT_OFF = 16'h270f;
  localparam logic [GW-1:0] GAIN_RST = 8'h64;
  localparam logic [GW-1:0] GAIN_MAX = 8'hc8;
  localparam logic [FW-1:0] MAXF_RST = 16'h2ee0;
  localparam logic VIS_RST = 1'b0;
  localparam logic [ACCW-1:0] DECAY_STEP = 24'h000010;

  // Interrupt bit positions
  localparam int IRQ_ACT = 0;
  localparam int IRQ_MAX = 1;
  localparam int IRQ_HOLD = 2;
  localparam int IRQ_REFUSE = 3;
  localparam int IRQ_N = 4;

  function automatic logic [FW-1:0] rafc_min(input logic [FW-1:0] a, input logic [FW-1:0] b);
    rafc_min = (a < b) ? a : b;
  endfunction
endpackage

// [src/rafc_lim_if.sv]
`timescale 1ns/1ps
interface rafc_lim_if;
  import rafc_pkg::*;
  logic [FW-1:0] base_freq;
  logic [FW-1:0] comp_raw;
  logic [FW-1:0] limit;
  logic [FW-1:0] max_freq;
  logic lim_en;
  logic decel;
  logic [FW-1:0] out_freq;
  logic [FW-1:0] comp_applied;
  logic hold;
  logic at_max;
  modport calc (input base_freq, comp_raw, limit, max_freq, lim_en, decel,
    output out_freq, comp_applied, hold, at_max);
  modport user (output base_freq, comp_raw, limit, max_freq, lim_en, decel,
    input out_freq, comp_applied, hold, at_max);
endinterface

// [src/rafc_limiter.sv]
`timescale 1ns/1ps
module rafc_limiter
  import rafc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  rafc_lim_if.calc lim
);
  logic [FW-1:0] next_comp;
  logic [FW:0] sum;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim.hold <= 1'b0;
    end else if (!lim.lim_en || !lim.decel || lim.base_freq <= (lim.limit >> 1)) begin
      lim.hold <= 1'b0;
    end else if (lim.comp_raw > lim.limit) begin
      lim.hold <= 1'b1;
    end
  end

  always_comb begin
    if (lim.hold) begin
      next_comp = lim.limit;
    end else if (lim.lim_en) begin
      next_comp = rafc_min(lim.comp_raw, lim.limit);
    end else begin
      next_comp = lim.comp_raw;
    end
    sum = {1'b0, lim.base_freq} + {1'b0, next_comp};
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lim.out_freq <= '0;
      lim.comp_applied <= '0;
      lim.at_max <= 1'b0;
    end else begin
      lim.comp_applied <= next_comp;
      if (sum > {1'b0, lim.max_freq}) begin
        lim.out_freq <= lim.max_freq;
        lim.at_max <= (next_comp != '0);
      end else begin
        lim.out_freq <= sum[FW-1:0];
        lim.at_max <= 1'b0;
      end
    end
  end
endmodule

// [src/rafc_top.sv]
`timescale 1ns/1ps
module rafc_top
  import rafc_pkg::*;
#(
  parameter bit VOLT_CLASS_400 = 1'b0
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [VW-1:0] bus_voltage,
  input wire logic [FW-1:0] base_freq,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic decel_stall_active,
  output logic [FW-1:0] output_freq,
  output logic overvoltage_stall_flag,
  output logic overvoltage_stall_event,
  output logic stall_prevention_req,
  output logic irq
);
  logic rst_meta;
  logic rst_n;
  logic [1:0] mode;
  logic [VW-1:0] level;
  logic [FW-1:0] limit;
  logic [GW-1:0] vgain;
  logic [GW-1:0] fgain;
  logic [FW-1:0] max_freq;
  logic vis;
  logic [IRQ_N-1:0] irq_stat;
  logic [IRQ_N-1:0] irq_en;
  logic [ACCW-1:0] acc;
  logic enabled;
  logic active;
  logic active_d;
  logic hold_d;
  logic at_max_d;
  logic [VW-1:0] excess;
  logic [25:0] excess_w;
  logic [25:0] vgain_w;
  logic [25:0] fgain_w;
  logic [25:0] product;
  logic [ACCW-1:0] inc;
  logic [ACCW-1:0] cap;
  logic [ACCW:0] acc_sum;
  logic [ACCW-1:0] next_acc;
  logic wr_acc;
  logic rd_setup;
  logic known;
  logic is_setting;
  logic value_ok;
  logic refuse;
  logic [IRQ_N-1:0] irq_set;
  logic [31:0] next_rdata;

  rafc_lim_if lim ();

  // Release held back two edges; assertion stays asynchronous
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    known = 1'b1;
    is_setting = 1'b1;
    value_ok = 1'b1;
    case (paddr)
      ADDR_MODE: value_ok = (pwdata[31:0] <= 32'h2);
      ADDR_LEVEL: value_ok = (pwdata[31:0] >= {22'h0, LEVEL_MIN}) &&
        (pwdata[31:0] <= {22'h0, LEVEL_MAX});
      ADDR_LIMIT: value_ok = (pwdata[31:0] <= {16'h0, LIMIT_MAX}) ||
        (pwdata[31:0] == {16'h0, LIMIT_OFF});
      ADDR_VGAIN, ADDR_FGAIN: value_ok = (pwdata[31:0] <= {24'h0, GAIN_MAX});
      ADDR_MAXF: value_ok = (pwdata[31:16] == 16'h0);
      ADDR_VIS, ADDR_IRQ_CLR, ADDR_IRQ_EN: is_setting = 1'b0;
      ADDR_STATUS, ADDR_IRQ_STAT: begin
        is_setting = 1'b0;
        value_ok = 1'b0;
      end
      default: begin
        known = 1'b0;
        is_setting = 1'b0;
      end
    endcase
  end

  assign refuse = !known || !value_ok || (is_setting && vis);
  // Error shown only in the access phase
  assign pslverr = psel && penable && pwrite ? refuse : (psel && penable && !known);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_RST;
      level <= VOLT_CLASS_400 ? LEVEL_RST_400V : LEVEL_RST_200V;
      limit <= LIMIT_RST;
      vgain <= GAIN_RST;
      fgain <= GAIN_RST;
      max_freq <= MAXF_RST;
    end else if (wr_acc && !refuse && is_setting) begin
      case (paddr)
        ADDR_MODE: mode <= pwdata[1:0];
        ADDR_LEVEL: level <= pwdata[VW-1:0];
        ADDR_LIMIT: limit <= pwdata[FW-1:0];
        ADDR_VGAIN: vgain <= pwdata[GW-1:0];
        ADDR_FGAIN: fgain <= pwdata[GW-1:0];
        ADDR_MAXF: max_freq <= pwdata[FW-1:0];
        default: mode <= mode;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vis <= VIS_RST;
    end else if (wr_acc && paddr == ADDR_VIS) begin
      vis <= pwdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= '0;
    end else if (wr_acc && paddr == ADDR_IRQ_EN) begin
      irq_en <= pwdata[IRQ_N-1:0];
    end
  end

  always_comb begin
    case (mode)
      MODE_ALWAYS: enabled = 1'b1;
      MODE_CONST: enabled = !accelerating && !decelerating;
      default: enabled = 1'b0;
    endcase
  end

  assign active = enabled && (bus_voltage >= level);
  assign excess = active ? bus_voltage - level : '0;

  // Widened first so the product cannot wrap
  assign excess_w = {16'h0, excess};
  assign vgain_w = {18'h0, vgain};
  assign fgain_w = {18'h0, fgain};
  assign product = excess_w * vgain_w * fgain_w;
  assign inc = ACCW'(product >> INC_SHIFT);
  assign cap = {(limit != LIMIT_OFF) ? rafc_min(limit, max_freq) : max_freq,
    ACC_FRAC'(0)};
  assign acc_sum = {1'b0, acc} + {1'b0, inc};

  // Slow decay keeps the output from stepping down at once
  always_comb begin
    if (active) begin
      next_acc = (acc_sum > {1'b0, cap}) ? cap : acc_sum[ACCW-1:0];
    end else if (acc > DECAY_STEP) begin
      next_acc = acc - DECAY_STEP;
    end else begin
      next_acc = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // Limiter owns the caps and the deceleration hold
  assign lim.base_freq = base_freq;
  assign lim.comp_raw = acc[ACCW-1:ACC_FRAC];
  assign lim.limit = limit;
  assign lim.max_freq = max_freq;
  assign lim.lim_en = (limit != LIMIT_OFF);
  assign lim.decel = decelerating;

  rafc_limiter u_limiter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lim(lim)
  );

  assign output_freq = lim.out_freq;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overvoltage_stall_flag <= 1'b0;
      overvoltage_stall_event <= 1'b0;
      stall_prevention_req <= 1'b0;
    end else begin
      overvoltage_stall_flag <= active;
      // event for flag item and timer
      overvoltage_stall_event <= active || decel_stall_active;
      stall_prevention_req <= active;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      // One-cycle history for edge detection
      active_d <= 1'b0;
      hold_d <= 1'b0;
      at_max_d <= 1'b0;
    end else begin
      active_d <= active;
      hold_d <= lim.hold;
      at_max_d <= lim.at_max;
    end
  end

  // Rising edge of each status condition sets its bit; every refused write sets IRQ_REFUSE
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_ACT] = active && !active_d;
    irq_set[IRQ_MAX] = lim.at_max && !at_max_d;
    irq_set[IRQ_HOLD] = lim.hold && !hold_d;
    irq_set[IRQ_REFUSE] = wr_acc && refuse;
  end

  // Set wins over clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
    end else if (wr_acc && paddr == ADDR_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~pwdata[IRQ_N-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  always_comb begin
    next_rdata = '0;
    case (paddr)
      ADDR_MODE: next_rdata[1:0] = mode;
      ADDR_LEVEL: next_rdata[VW-1:0] = level;
      ADDR_LIMIT: next_rdata[FW-1:0] = limit;
      ADDR_VGAIN: next_rdata[GW-1:0] = vgain;
      ADDR_FGAIN: next_rdata[GW-1:0] = fgain;
      ADDR_MAXF: next_rdata[FW-1:0] = max_freq;
      ADDR_VIS: next_rdata[0] = vis;
      ADDR_STATUS: next_rdata = {lim.comp_applied, 13'h0, lim.at_max, lim.hold, active};
      ADDR_IRQ_STAT: next_rdata[IRQ_N-1:0] = irq_stat;
      ADDR_IRQ_EN: next_rdata[IRQ_N-1:0] = irq_en;
      default: next_rdata = '0;
    endcase
  end

  // Read data captured in setup phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end
endmodule

// [testbench/rafc_top_sva.sv]
`timescale 1ns/1ps
module rafc_top_sva
  import rafc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [VW-1:0] bus_voltage,
  input wire logic [FW-1:0] base_freq,
  input wire logic accelerating,
  input wire logic decelerating,
  input wire logic decel_stall_active,
  input wire logic [FW-1:0] output_freq,
  input wire logic overvoltage_stall_flag,
  input wire logic overvoltage_stall_event,
  input wire logic stall_prevention_req,
  input wire logic irq
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_stall_same: assert property (stall_prevention_req == overvoltage_stall_flag)
    else $error("stall request differs from flag");
  a_event_or: assert property (overvoltage_stall_event ==
    (overvoltage_stall_flag | $past(decel_stall_active)))
    else $error("stall event wrong");
  a_flag_cause: assert property ($rose(overvoltage_stall_flag) |->
    $past(bus_voltage) >= LEVEL_MIN)
    else $error("flag rose below any level");
  a_flag_drop: assert property (overvoltage_stall_flag && bus_voltage < LEVEL_MIN
    |=> !overvoltage_stall_flag)
    else $error("flag held below level");
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmap_err: assert property (psel && penable && paddr > ADDR_IRQ_EN |-> pslverr)
    else $error("unmapped access not refused");
  a_unmap_zero: assert property (psel && !penable && !pwrite && paddr > ADDR_IRQ_EN
    |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_status_ro: assert property (psel && penable && pwrite && paddr == ADDR_STATUS
    |-> pslverr)
    else $error("status write accepted");
  a_irq_mask: assert property (psel && penable && pwrite && paddr == ADDR_IRQ_EN &&
    pwdata == 32'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
endmodule
bind rafc_top rafc_top_sva chk (.*);

// [testbench/rafc_drive_model.sv]
`timescale 1ns/1ps
module rafc_drive_model
  import rafc_pkg::*;
#(
  parameter logic [VW-1:0] NOMINAL_V = 10'h137
)
(
  input wire logic core_clk,
  input wire logic regen,
  input wire logic [VW-1:0] regen_v,
  input wire logic [FW-1:0] freq_set,
  input wire logic acc_set,
  input wire logic dec_set,
  output logic [VW-1:0] bus_voltage = 10'h137,
  output logic [FW-1:0] base_freq = 16'h0,
  output logic accelerating = 1'h0,
  output logic decelerating = 1'h0,
  output logic decel_stall_active = 1'h0
);
  always @(posedge core_clk) begin
    bus_voltage <= regen ? regen_v : NOMINAL_V;
    base_freq <= freq_set;
    accelerating <= acc_set;
    decelerating <= dec_set;
    decel_stall_active <= dec_set & regen;
  end
endmodule

// [testbench/rafc_top_test.sv]
`timescale 1ns/1ps
module rafc_top_test;
  import rafc_pkg::*;
  logic core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [AW-1:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, accelerating, decelerating, decel_stall_active, e;
  logic [VW-1:0] bus_voltage;
  logic [FW-1:0] base_freq, output_freq;
  logic overvoltage_stall_flag, overvoltage_stall_event, stall_prevention_req, irq;
  logic regen = 1'h0, acc_set = 1'h0, dec_set = 1'h0;
  logic [VW-1:0] regen_v = 10'h320;
  logic [FW-1:0] freq_set = 16'h03e8;
  int n_errors = 0, n_tests = 0;
  rafc_top dut (.*);
  rafc_drive_model model (.core_clk(core_clk), .regen(regen), .regen_v(regen_v),
    .freq_set(freq_set), .acc_set(acc_set), .dec_set(dec_set), .bus_voltage(bus_voltage),
    .base_freq(base_freq), .accelerating(accelerating), .decelerating(decelerating),
    .decel_stall_active(decel_stall_active));
  initial forever #4 core_clk = ~core_clk;
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    @(posedge core_clk);
    while (pready !== 1'h1) @(posedge core_clk);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic ee);
    apb(1'h1, a, d);
    chk_bit(e, ee);
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic vstep(input logic [VW-1:0] v, input logic f);
    regen_v <= v;
    wc(4);
    chk_bit(overvoltage_stall_flag, f);
  endtask
  initial begin
    wc(20000);
    n_errors++;
    test_done();
  end
  initial begin
    wc(3);
    reset_n <= 1'h1;
    wc(4);
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_LEVEL, 32'h190);
    rd(ADDR_LIMIT, 32'h258);
    rd(ADDR_VGAIN, 32'h64);
    rd(ADDR_FGAIN, 32'h64);
    rd(ADDR_MAXF, 32'h2ee0);
    rd(8'h40, 32'h0);
    wr(ADDR_STATUS, 32'h0, 1'h1);
    wr(ADDR_MODE, 32'h3, 1'h1);
    wr(ADDR_LEVEL, 32'h12b, 1'h1);
    wr(ADDR_LEVEL, 32'h321, 1'h1);
    wr(ADDR_LIMIT, 32'h3e9, 1'h1);
    wr(ADDR_VGAIN, 32'hc9, 1'h1);
    wr(ADDR_FGAIN, 32'hc9, 1'h1);
    wr(ADDR_VIS, 32'h1, 1'h0);
    wr(ADDR_MODE, 32'h1, 1'h1);
    wr(ADDR_VIS, 32'h0, 1'h0);
    rd(ADDR_MODE, 32'h0);
    wr(ADDR_LIMIT, 32'h270f, 1'h0);
    wr(ADDR_LIMIT, 32'h258, 1'h0);
    wr(ADDR_IRQ_CLR, 32'hf, 1'h0);
    rd(ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_IRQ_EN, 32'h9, 1'h0);
    regen <= 1'h1;
    wc(20);
    chk_bit(overvoltage_stall_flag, 1'h0);
    chk({16'h0, output_freq}, 32'h3e8);
    wr(ADDR_VGAIN, 32'h0, 1'h0);
    wr(ADDR_MODE, 32'h1, 1'h0);
    wc(20);
    chk_bit(overvoltage_stall_flag, 1'h1);
    chk({16'h0, output_freq}, 32'h3e8);
    wr(ADDR_FGAIN, 32'h0, 1'h0);
    wr(ADDR_VGAIN, 32'h64, 1'h0);
    wc(20);
    chk({16'h0, output_freq}, 32'h3e8);
    wr(ADDR_FGAIN, 32'h64, 1'h0);
    wc(400);
    chk_bit(overvoltage_stall_flag, 1'h1);
    chk({16'h0, output_freq}, 32'h640);
    chk_bit(irq, 1'h1);
    rd(ADDR_IRQ_STAT, 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1, 1'h0);
    wc(2);
    chk_bit(irq, 1'h0);
    dec_set <= 1'h1;
    wr(ADDR_LIMIT, 32'hc8, 1'h0);
    wc(8);
    chk({16'h0, output_freq}, 32'h4b0);
    rd(ADDR_STATUS, 32'h00c80003);
    rd(ADDR_IRQ_STAT, 32'h4);
    regen <= 1'h0;
    wc(8);
    chk({16'h0, output_freq}, 32'h4b0);
    freq_set <= 16'h0064;
    wc(3300);
    chk({16'h0, output_freq}, 32'h64);
    freq_set <= 16'h03e8;
    regen <= 1'h1;
    wc(80);
    wr(ADDR_IRQ_CLR, 32'hf, 1'h0);
    dec_set <= 1'h0;
    wr(ADDR_MAXF, 32'h44c, 1'h0);
    wc(8);
    chk({16'h0, output_freq}, 32'h44c);
    chk_bit(irq, 1'h0);
    wr(ADDR_MODE, 32'h5, 1'h1);
    wc(2);
    chk_bit(irq, 1'h1);
    wr(ADDR_IRQ_EN, 32'h0, 1'h0);
    wr(ADDR_MODE, 32'h2, 1'h0);
    acc_set <= 1'h1;
    wc(4);
    chk_bit(overvoltage_stall_flag, 1'h0);
    acc_set <= 1'h0;
    wc(4);
    chk_bit(overvoltage_stall_flag, 1'h1);
    wr(ADDR_LEVEL, 32'h320, 1'h0);
    vstep(10'h320, 1'h1);
    vstep(10'h31f, 1'h0);
    vstep(10'h320, 1'h1);
    vstep(10'h12b, 1'h0);
    test_done();
  end
endmodule
